// File: src/afo_pkg.sv
// Package for the converter mode register bank: map, fields, types
package afo_pkg;

   // Register addresses within each group copy
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
   localparam logic [6:0] ADDR_FORMAT = 7'h01;
   localparam logic [6:0] ADDR_OUT_MODE = 7'h02;
   localparam logic [7:0] MODE_RESET_VAL = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Format and power-down fields
   localparam int FMT_DCS_BIT = 7;
   localparam int FMT_SCRAMBLE_BIT = 6;
   localparam int FMT_SIGNED_BIT = 5;
   localparam int FMT_SLEEP_BIT = 4;
   localparam int FMT_NAP_MSB = 3;
   localparam int FMT_NAP_LSB = 0;

   // Output mode fields
   localparam int OM_CUR_MSB = 7;
   localparam int OM_CUR_LSB = 5;
   localparam int OM_TERM_BIT = 4;
   localparam int OM_OFF_BIT = 3;
   localparam int OM_LANE_MSB = 2;
   localparam int OM_LANE_LSB = 0;

   // Serial framing: read flag in command byte, reset request bit
   localparam int CMD_READ_BIT = 7;
   localparam int SOFT_RESET_BIT = 7;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Group copy indices and zero-based channel numbers per nap bit
   localparam int GRP_A = 0;
   localparam int GRP_B = 1;
   localparam int GRP_A_CH [0:3] = '{0, 3, 4, 7};
   localparam int GRP_B_CH [0:3] = '{1, 2, 5, 6};

   // Idle level of the synchronised pins: selects high
   localparam logic [3:0] PINS_IDLE = 4'h3;

   typedef enum logic [1:0] {AFO_IDLE, AFO_CMD, AFO_DATA, AFO_DONE} afo_phase_t;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic sel_a_n;
      logic sel_b_n;
   } afo_pins_t;

   typedef struct packed {
      logic duty_stabilizer_disable;
      logic output_scramble_enable;
      logic signed_format_select;
      logic sleep;
      logic [3:0] nap;
      logic [2:0] driver_current_select;
      logic [8:0] driver_current_ca;
      logic internal_termination_enable;
      logic output_disable;
      logic [2:0] lane_mode_select;
   } afo_grp_mode_t;

   typedef struct packed {
      afo_pins_t s1;
      afo_pins_t s2;
      afo_pins_t s3;
      afo_pins_t filt;
      afo_phase_t phase;
      logic [2:0] cnt;
      logic [7:0] cmd;
      logic [7:0] data;
      logic [7:0] tx;
      logic [1:0] sel;
      logic [1:0][7:0] fmt_reg;
      logic [1:0][7:0] omode_reg;
      logic sdo;
      logic sdo_oe;
   } afo_state_t;

   // Driver current in hundredths of a milliamp; unused code keeps the default
   function automatic logic [8:0] afo_current_ca(input logic [2:0] code);
      case (code)
         3'h1: afo_current_ca = 9'h190;
         3'h2: afo_current_ca = 9'h1c2;
         3'h4: afo_current_ca = 9'h12c;
         3'h5: afo_current_ca = 9'h0fa;
         3'h6: afo_current_ca = 9'h0d2;
         3'h7: afo_current_ca = 9'h0af;
         default: afo_current_ca = 9'h15e;
      endcase
   endfunction : afo_current_ca

endpackage : afo_pkg

// File: src/afo_mode_regs.sv
// Serial-programmed format, power-down and output mode registers, two group copies
//
// Contract
// - Address 01h with group B selected: format
// - Bit 7 turns duty stabilizer off
// - Bit 6 enables output scrambling
// - Nap bits 0-3 nap channels 2,3,6,7
// - Top power-down bit sleeps whole group
// - Any nap combination, each channel independent
// - Address 02h output mode field layout
// - Current field decodes to driver current
// - Each select owns its own register copy
// - Bit 5 selects two's complement format
// - Software reset clears mode registers to 00h
`timescale 1ns/1ns
`default_nettype none
module afo_mode_regs
   import afo_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic sdi,
   input wire logic group_a_select_n,
   input wire logic group_b_select_n,
   output logic sdo,
   output logic sdo_oe,
   output afo_grp_mode_t group_a_mode,
   output afo_grp_mode_t group_b_mode,
   output logic [7:0] channel_nap,
   output logic [7:0] channel_enable,
   output logic [1:0] out_drive_en
);

   afo_state_t st_reg;
   afo_state_t st_next;
   afo_pins_t filt_next;
   logic sck_rise;
   logic sck_fall;
   logic any_sel;
   logic commit;
   logic [6:0] commit_addr;
   logic [7:0] commit_byte;

   // Pin filter: a high level counts once stages two and three agree, a low level as soon as they differ
   assign filt_next = (st_reg.filt & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3));
   assign sck_rise = filt_next.sck & ~st_reg.filt.sck;
   assign sck_fall = ~filt_next.sck & st_reg.filt.sck;
   assign any_sel = ~filt_next.sel_a_n | ~filt_next.sel_b_n;

   // Write lands on the last data rising edge, not on select release
   assign commit = any_sel && st_reg.phase == AFO_DATA && sck_rise && st_reg.cnt == BIT_LAST
      && !st_reg.cmd[CMD_READ_BIT];
   assign commit_addr = st_reg.cmd[6:0];
   assign commit_byte = {st_reg.data[6:0], filt_next.sdi};

   // Read mux; with both selects low group A answers
   function automatic logic [7:0] read_reg(input afo_state_t s, input logic [6:0] addr);
      int g;
      g = s.sel[GRP_A] ? GRP_A : GRP_B;
      case (addr)
         ADDR_FORMAT: read_reg = s.fmt_reg[g];
         ADDR_OUT_MODE: read_reg = s.omode_reg[g];
         default: read_reg = READ_UNMAPPED;
      endcase
   endfunction : read_reg

   // Serial engine and register updates
   always_comb begin
      st_next = st_reg;
      st_next.s1 = '{sck: sck, sdi: sdi, sel_a_n: group_a_select_n, sel_b_n: group_b_select_n};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.filt = filt_next;
      if (!any_sel) begin
         st_next.phase = AFO_IDLE;
         st_next.sdo_oe = 1'b0;
      end else begin
         unique case (st_reg.phase)
            AFO_IDLE: begin
               st_next.phase = AFO_CMD;
               st_next.cnt = '0;
               st_next.sel = {~filt_next.sel_b_n, ~filt_next.sel_a_n};
            end
            AFO_CMD: begin
               if (sck_rise) begin
                  st_next.cmd = {st_reg.cmd[6:0], filt_next.sdi};
                  st_next.cnt = st_reg.cnt + 3'h1;
                  if (st_reg.cnt == BIT_LAST) begin
                     st_next.phase = AFO_DATA;
                     if (st_next.cmd[CMD_READ_BIT]) begin
                        st_next.tx = read_reg(st_reg, st_next.cmd[6:0]);
                        st_next.sdo = st_next.tx[7];
                        st_next.sdo_oe = 1'b1;
                     end
                  end
               end
            end
            AFO_DATA: begin
               // First falling edge is skipped so bit 7 is held a full period
               if (sck_fall && st_reg.cnt != 3'h0) begin
                  st_next.tx = {st_reg.tx[6:0], 1'b0};
                  st_next.sdo = st_next.tx[7];
               end
               if (sck_rise) begin
                  st_next.data = commit_byte;
                  st_next.cnt = st_reg.cnt + 3'h1;
                  if (st_reg.cnt == BIT_LAST) begin
                     st_next.phase = AFO_DONE;
                  end
               end
            end
            AFO_DONE: begin
               // Extra clocks in the frame are ignored
               st_next.sdo_oe = 1'b0;
            end
         endcase
      end
      if (commit) begin
         for (int g = 0; g < 2; g++) begin
            if (st_reg.sel[g]) begin
               unique case (commit_addr)
                  ADDR_FORMAT: st_next.fmt_reg[g] = commit_byte;
                  ADDR_OUT_MODE: st_next.omode_reg[g] = commit_byte;
                  ADDR_SOFT_RESET: begin
                     if (commit_byte[SOFT_RESET_BIT]) begin
                        st_next.fmt_reg[g] = MODE_RESET_VAL;
                        st_next.omode_reg[g] = MODE_RESET_VAL;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // State register; pins idle with selects released
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.s1 <= PINS_IDLE;
         st_reg.s2 <= PINS_IDLE;
         st_reg.s3 <= PINS_IDLE;
         st_reg.filt <= PINS_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Field breakout per group copy
   function automatic afo_grp_mode_t unpack_mode(input logic [7:0] f, input logic [7:0] o);
      unpack_mode.duty_stabilizer_disable = f[FMT_DCS_BIT];
      unpack_mode.output_scramble_enable = f[FMT_SCRAMBLE_BIT];
      unpack_mode.signed_format_select = f[FMT_SIGNED_BIT];
      unpack_mode.sleep = f[FMT_SLEEP_BIT];
      unpack_mode.nap = f[FMT_NAP_MSB:FMT_NAP_LSB];
      unpack_mode.driver_current_select = o[OM_CUR_MSB:OM_CUR_LSB];
      unpack_mode.driver_current_ca = afo_current_ca(o[OM_CUR_MSB:OM_CUR_LSB]);
      unpack_mode.internal_termination_enable = o[OM_TERM_BIT];
      unpack_mode.output_disable = o[OM_OFF_BIT];
      unpack_mode.lane_mode_select = o[OM_LANE_MSB:OM_LANE_LSB];
   endfunction : unpack_mode

   assign group_a_mode = unpack_mode(st_reg.fmt_reg[GRP_A], st_reg.omode_reg[GRP_A]);
   assign group_b_mode = unpack_mode(st_reg.fmt_reg[GRP_B], st_reg.omode_reg[GRP_B]);
   assign sdo = st_reg.sdo;
   assign sdo_oe = st_reg.sdo_oe;
   assign out_drive_en = {~group_b_mode.output_disable, ~group_a_mode.output_disable};

   // Channel power states; sleep overrides the nap bits
   always_comb begin
      channel_nap = '0;
      channel_enable = '0;
      for (int i = 0; i < 4; i++) begin
         channel_nap[GRP_A_CH[i]] = group_a_mode.nap[i] & ~group_a_mode.sleep;
         channel_nap[GRP_B_CH[i]] = group_b_mode.nap[i] & ~group_b_mode.sleep;
         channel_enable[GRP_A_CH[i]] = ~(group_a_mode.nap[i] | group_a_mode.sleep);
         channel_enable[GRP_B_CH[i]] = ~(group_b_mode.nap[i] | group_b_mode.sleep);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fmt_write_b: assert property (commit && commit_addr == ADDR_FORMAT && st_reg.sel == 2'h2
      |=> st_reg.fmt_reg[GRP_B] == $past(commit_byte) && $stable(st_reg.fmt_reg[GRP_A]))
      else $error("group B format write not applied alone");
   a_dcs_follows: assert property (commit && commit_addr == ADDR_FORMAT && st_reg.sel[GRP_B]
      |=> group_b_mode.duty_stabilizer_disable == $past(commit_byte[FMT_DCS_BIT]))
      else $error("stabilizer disable does not follow write");
   a_scramble_follows: assert property (commit && commit_addr == ADDR_FORMAT && st_reg.sel[GRP_B]
      |=> group_b_mode.output_scramble_enable == $past(commit_byte[FMT_SCRAMBLE_BIT]))
      else $error("scramble enable does not follow write");
   a_signed_follows: assert property (commit && commit_addr == ADDR_FORMAT && st_reg.sel[GRP_B]
      |=> group_b_mode.signed_format_select == $past(commit_byte[FMT_SIGNED_BIT]))
      else $error("format select does not follow write");
   a_nap_ch_map: assert property (!st_reg.fmt_reg[GRP_B][FMT_SLEEP_BIT]
      |-> {channel_nap[6], channel_nap[5], channel_nap[2], channel_nap[1]} == st_reg.fmt_reg[GRP_B][3:0])
      else $error("group B nap bits mapped to wrong channels");
   a_sleep_all_off: assert property (group_b_mode.sleep
      |-> !channel_enable[1] && !channel_enable[2] && !channel_enable[5] && !channel_enable[6] && !channel_nap[1])
      else $error("sleep left a group B channel running");
   a_nap_independent: assert property (!group_a_mode.sleep && !group_a_mode.nap[0]
      |-> channel_enable[0] && channel_nap[3] == group_a_mode.nap[1])
      else $error("nap of one channel disturbs another");
   a_omode_write: assert property (commit && commit_addr == ADDR_OUT_MODE && st_reg.sel == 2'h1
      |=> group_a_mode.lane_mode_select == $past(commit_byte[2:0]) && $stable(st_reg.omode_reg[GRP_B]))
      else $error("output mode write misplaced");
   a_current_decode: assert property (group_a_mode.driver_current_select == 3'h5
      |-> group_a_mode.driver_current_ca == 9'h0fa)
      else $error("driver current decode wrong");
   a_soft_reset_clear: assert property (commit && commit_addr == ADDR_SOFT_RESET
      && commit_byte[SOFT_RESET_BIT] && st_reg.sel[GRP_B]
      |=> st_reg.fmt_reg[GRP_B] == MODE_RESET_VAL && st_reg.omode_reg[GRP_B] == MODE_RESET_VAL)
      else $error("software reset did not clear registers");
   a_out_disable: assert property ($rose(group_a_mode.output_disable) |-> !out_drive_en[0])
      else $error("outputs still driven while disabled");

   c_read_frame: cover property (st_reg.phase == AFO_DATA && sdo_oe ##1 !sdo_oe);
   c_write_b: cover property (commit && st_reg.sel == 2'h2);
   c_soft_reset: cover property (commit && commit_addr == ADDR_SOFT_RESET && commit_byte[SOFT_RESET_BIT]);
   c_sleep: cover property ($rose(group_b_mode.sleep));

endmodule : afo_mode_regs
`default_nettype wire

// File: verification/afo_host_model.sv
// Host model: drives select, serial clock and data pins, captures read data
`timescale 1ns/1ns
`default_nettype none
module afo_host_model
   import afo_pkg::*;
(
   input wire logic clk,
   output logic sck,
   output logic sdi,
   output logic group_a_select_n,
   output logic group_b_select_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   output logic [7:0] rd_data,
   output logic rd_valid
);
   // Idle pins: selects high, clock still
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      group_a_select_n = 1'b1;
      group_b_select_n = 1'b1;
      rd_data = 8'h00;
      rd_valid = 1'b0;
   end

   // One frame; each level held 8 clocks, well over the filter's need
   task automatic xfer(input logic [1:0] sel, input logic [15:0] word);
      @(negedge clk);
      rd_valid = 1'b0;
      group_a_select_n = ~sel[0];
      group_b_select_n = ~sel[1];
      repeat (8) @(negedge clk);
      for (int k = 15; k >= 0; k--) begin
         sdi = word[k];
         repeat (8) @(negedge clk);
         // Read bit settles during the low phase; undriven line marks a miss
         if (k < 8 && word[15]) begin
            rd_data[k] = (sdo_oe === 1'b1) ? sdo : 1'bx;
         end
         sck = 1'b1;
         repeat (8) @(negedge clk);
         sck = 1'b0;
      end
      // Released data line shows the inverse of its last value
      sdi = ~sdi;
      group_a_select_n = 1'b1;
      group_b_select_n = 1'b1;
      rd_valid = word[15];
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : afo_host_model
`default_nettype wire

// File: verification/adc_format_output_mode_regs_bench.sv
// Self-checking bench for the mode register bank
`timescale 1ns/1ns
`default_nettype none
module adc_format_output_mode_regs_bench;
   import afo_pkg::*;
   logic clk, rst, sck, sdi, sel_a_n, sel_b_n, sdo, sdo_oe, rd_valid;
   logic [7:0] rd_data, channel_nap, channel_enable;
   logic [1:0] out_drive_en;
   afo_grp_mode_t group_a_mode, group_b_mode;
   logic [7:0] exp_q [$];
   logic [1:0][7:0] fmt_m, om_m;
   logic [31:0] seed = 32'h0000_c01c;
   logic [7:0] pat [4] = '{8'h1f, 8'h0f, 8'h0a, 8'he0};
   logic [8:0] cur_tab [8] = '{9'h15e, 9'h190, 9'h1c2, 9'h15e, 9'h12c, 9'h0fa, 9'h0d2, 9'h0af};
   int mismatches = 0;
   int n_checks = 0;

   afo_mode_regs afo_mode_regs_i (.clk(clk), .rst(rst), .sck(sck), .sdi(sdi), .group_a_select_n(sel_a_n),
      .group_b_select_n(sel_b_n), .sdo(sdo), .sdo_oe(sdo_oe), .group_a_mode(group_a_mode),
      .group_b_mode(group_b_mode), .channel_nap(channel_nap), .channel_enable(channel_enable),
      .out_drive_en(out_drive_en));
   afo_host_model afo_host_model_i (.clk(clk), .sck(sck), .sdi(sdi), .group_a_select_n(sel_a_n),
      .group_b_select_n(sel_b_n), .sdo(sdo), .sdo_oe(sdo_oe), .rd_data(rd_data), .rd_valid(rd_valid));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction : xorshift

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // Expected decode of both copies from the bench's own register image
   task automatic chk_all();
      afo_grp_mode_t e [2];
      logic [7:0] nap, en;
      int ch;
      nap = '0;
      en = '1;
      for (int g = 0; g < 2; g++) begin
         e[g] = {fmt_m[g], om_m[g][7:5], cur_tab[om_m[g][7:5]], om_m[g][4:0]};
         for (int i = 0; i < 4; i++) begin
            ch = (g == GRP_A) ? GRP_A_CH[i] : GRP_B_CH[i];
            nap[ch] = fmt_m[g][4] ? 1'b0 : fmt_m[g][i];
            en[ch] = ~(fmt_m[g][4] | fmt_m[g][i]);
         end
      end
      check("group a mode", group_a_mode, e[0]);
      check("group b mode", group_b_mode, e[1]);
      check("channel nap", channel_nap, nap);
      check("channel enable", channel_enable, en);
      check("drive enable", out_drive_en, {~om_m[1][3], ~om_m[0][3]});
   endtask : chk_all

   // Write: update image per selected copy, then compare decoded outputs
   task automatic wr(input logic [1:0] sel, input logic [6:0] a, input logic [7:0] d);
      afo_host_model_i.xfer(sel, {1'b0, a, d});
      for (int g = 0; g < 2; g++) begin
         if (sel[g] && a == ADDR_FORMAT) fmt_m[g] = d;
         if (sel[g] && a == ADDR_OUT_MODE) om_m[g] = d;
         if (sel[g] && a == ADDR_SOFT_RESET && d[7]) {fmt_m[g], om_m[g]} = '0;
      end
      chk_all();
   endtask : wr

   // Read: note the expected byte, the watcher compares it
   task automatic rd(input logic [1:0] sel, input logic [6:0] a);
      int g;
      g = sel[0] ? GRP_A : GRP_B;
      exp_q.push_back(a == ADDR_FORMAT ? fmt_m[g] : (a == ADDR_OUT_MODE ? om_m[g] : 8'h00));
      afo_host_model_i.xfer(sel, {1'b1, a, 8'h00});
   endtask : rd

   // Watcher: oldest note against each finished read
   always @(posedge rd_valid) begin
      check("read data", rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
   end

   initial begin
      rst = 1'b1;
      fmt_m = '0;
      om_m = '0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      chk_all();
      // Fixed nap/sleep corners into group B, then random awake words into both copies
      for (int n = 0; n < 8; n++) begin
         seed = xorshift(seed);
         wr((n < 4) ? 2'b10 : 2'b11, ADDR_FORMAT, (n < 4) ? pat[n] : {seed[7:5], 1'b0, seed[3:0]});
         rd(2'b10, ADDR_FORMAT);
         rd(2'b01, ADDR_FORMAT);
      end
      // Every current code, output disable toggled; codes 6 and 7 land in group B
      for (int c = 0; c < 8; c++) begin
         seed = xorshift(seed);
         wr((c < 6) ? 2'b01 : 2'b10, ADDR_OUT_MODE, {c[2:0], seed[4], c[0], seed[2:0]});
         rd((c < 6) ? 2'b01 : 2'b10, ADDR_OUT_MODE);
      end
      wr(2'b11, ADDR_FORMAT, 8'h3c);
      rd(2'b11, ADDR_FORMAT);
      wr(2'b10, 7'h05, 8'hff);
      rd(2'b10, 7'h05);
      rd(2'b10, ADDR_SOFT_RESET);
      wr(2'b10, ADDR_SOFT_RESET, 8'h80);
      rd(2'b01, ADDR_OUT_MODE);
      repeat (4) @(posedge clk);
      check("pending reads", exp_q.size(), 0);
      results();
   end

   // Watchdog well beyond the ~12800 clocks of traffic
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule : adc_format_output_mode_regs_bench
`default_nettype wire
